// >>> hw/lcr_defines.svh
// Register offsets, reset values, field positions and host command layout
`ifndef LCR_DEFINES_SVH
`define LCR_DEFINES_SVH
// Device register offsets
`define LCR_OFS_ENABLE 12'h200
`define LCR_OFS_MODE 12'h201
`define LCR_OFS_FPMF 12'h202
`define LCR_OFS_SYNC 12'h203
`define LCR_OFS_CTRL 12'h204
// Device reset values
`define LCR_RST_ENABLE 8'h01
`define LCR_RST_MODE 8'h02
`define LCR_RST_FPMF 8'h1f
`define LCR_RST_SYNC 8'h01
`define LCR_RST_CTRL 8'h03
// Field positions
`define LCR_BIT_EN 0
`define LCR_BIT_SYNC 0
`define LCR_BIT_SCR 0
`define LCR_BIT_FMT 1
`define LCR_SEL_LO 2
`define LCR_SEL_HI 3
`define LCR_BIT_UPPER 4
// Sync source codes
`define LCR_SEL_SE 2'h0
`define LCR_SEL_TS 2'h1
`define LCR_SEL_SW 2'h2
// Link mode decoding
`define LCR_MODE_66B_MIN 8'h10
`define LCR_MODE_F_LO 0
`define LCR_MODE_F_HI 1
`define LCR_MODE_E_BIT 2
`define LCR_EMB_BASE 11'h100
`define LCR_K_ONE 11'h001
// Serializer power-down masks, one bit per lane
`define LCR_LANES_ALL 8'hff
`define LCR_LANES_UPPER_OFF 8'hf0
`define LCR_LANES_LOWER_OFF 8'h0f
// Host AHB register offsets
`define LCR_AHB_CMD 8'h00
`define LCR_AHB_STATUS 8'h04
`define LCR_AHB_PINS 8'h08
`define LCR_HSIZE_WORD 3'h2
`define LCR_HTRANS_ACT 1
// Host command word fields
`define LCR_CMD_A_HI 11
`define LCR_CMD_A_LO 0
`define LCR_CMD_D_HI 19
`define LCR_CMD_D_LO 12
`define LCR_CMD_WR 24
// Host status and pin fields
`define LCR_ST_BUSY 0
`define LCR_ST_REFUSED 1
`define LCR_ST_D_LO 8
`define LCR_PIN_SE 0
`define LCR_PIN_TS 1
`define LCR_PIN_CAL 2
`define LCR_PIN_SYSREF 3
`define LCR_PINS_RST 4'h3
`endif

// >>> hw/lcr_pkg.sv
// Types shared by both ends of the link control register port
package lcr_pkg;
    typedef logic [11:0] lcr_addr_t;
    typedef logic [7:0] lcr_byte_t;
    typedef logic [8:0] lcr_kcount_t;
    typedef enum logic [2:0] {
        LCR_HS_IDLE = 3'h1,
        LCR_HS_WRITE = 3'h2,
        LCR_HS_READ = 3'h4
    } lcr_host_state_e;
endpackage

// >>> hw/lcr_if.sv
// Register port and sync pins between the host controller and the converter
`timescale 1ns/1ps
interface lcr_if;
    lcr_pkg::lcr_addr_t reg_addr;
    lcr_pkg::lcr_byte_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    lcr_pkg::lcr_byte_t reg_rdata;
    logic reg_rvalid;
    logic single_ended_sync_pin_n;
    logic timestamp_pin_n;
    logic sysref;
    logic cal_enable;
    modport device (
        input reg_addr, reg_wdata, reg_wr, reg_rd,
        input single_ended_sync_pin_n, timestamp_pin_n, sysref, cal_enable,
        output reg_rdata, reg_rvalid
    );
    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        output single_ended_sync_pin_n, timestamp_pin_n, sysref, cal_enable,
        input reg_rdata, reg_rvalid
    );
endinterface

// >>> hw/lcr_mf_counter.sv
// Multiframe clock counter with hold and SYSREF realignment
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_mf_counter (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic hold_in,
    input wire logic sysref_in,
    input wire lcr_pkg::lcr_kcount_t k_minus_one_in,
    // Status
    output lcr_pkg::lcr_kcount_t count_out,
    output logic start_out
);
    import lcr_pkg::*;
    logic sysref_reg;
    lcr_kcount_t count_next;

    always_comb begin
        if (sysref_in && !sysref_reg) begin
            count_next = '0;
        end else if (count_out >= k_minus_one_in) begin
            count_next = '0;
        end else begin
            count_next = count_out + 9'h001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || hold_in) begin
            sysref_reg <= 1'b0;
        end else begin
            sysref_reg <= sysref_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || hold_in) begin
            count_out <= '0;
            start_out <= 1'b0;
        end else begin
            count_out <= count_next;
            start_out <= (count_next == '0);
        end
    end
endmodule // lcr_mf_counter

// >>> hw/lcr_device.sv
// Converter end: link control registers and their effect on the link
`timescale 1ns/1ps
`include "lcr_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Enable bit switches link; resets to one
// - Disabled link: reset, serializers off, clocks gated
// - Disabled link holds multiframe counter in reset
// - Host clears enable before other config writes
// - Host sets calibration before setting enable
// - Host clears enable before clearing calibration
// - Mode changes only with enable, calibration off
// - Only lock-permitted link modes are accepted
// - Frame field holds frames minus one
// - 64b/66b modes derive frames from mode
// - Frame field changed only while disabled
// - Writing zero to sync bit requests sync
// - Software request adds to any pin request
// - Stuck pin released by source two or three
// - Source field picks sync pin or software
// - Format bit picks offset binary or signed
// - Whitening bit; always on in 64b/66b
// - Lane mapping bit selects upper lanes
module lcr_device (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Straps
    input wire lcr_pkg::lcr_byte_t mode_lock_in,
    input wire logic timestamp_receiver_enable_in,
    // Register port and sync pins
    lcr_if.device link,
    // Link control
    output logic link_reset_out,
    output logic link_clock_enable_out,
    output lcr_pkg::lcr_byte_t serializer_power_down_out,
    output logic sample_format_out,
    output logic whitening_enable_out,
    output logic sync_request_out,
    // Multiframe timing
    output lcr_pkg::lcr_kcount_t frames_per_multiframe_minus_one_out,
    output lcr_pkg::lcr_kcount_t multiframe_count_out,
    output logic multiframe_start_out
);
    import lcr_pkg::*;

    lcr_byte_t link_enable_reg;
    lcr_byte_t link_mode_reg;
    lcr_byte_t frames_per_multiframe_reg;
    lcr_byte_t software_sync_request_reg;
    lcr_byte_t link_control_reg;
    lcr_byte_t reg_rdata_reg;
    logic reg_rvalid_reg;
    logic link_enable;
    logic mode_is_66b;
    logic pin_request;
    logic [1:0] sync_source;
    lcr_kcount_t k_minus_one;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_write(input lcr_addr_t ofs);
        return link.reg_wr && (link.reg_addr == ofs);
    endfunction

    function automatic logic mode_allowed(input lcr_byte_t mode, input lcr_byte_t lock);
        return mode <= lock;
    endfunction

    function automatic logic is_66b(input lcr_byte_t mode);
        return mode >= `LCR_MODE_66B_MIN;
    endfunction

    function automatic lcr_kcount_t derive_k(input lcr_byte_t mode, input lcr_byte_t fpmf);
        logic [10:0] k_full;
        k_full = `LCR_EMB_BASE;
        if (is_66b(mode)) begin
            k_full = `LCR_EMB_BASE << mode[`LCR_MODE_E_BIT];
            k_full = k_full >> mode[`LCR_MODE_F_HI:`LCR_MODE_F_LO];
            k_full = k_full - `LCR_K_ONE;
            return k_full[8:0];
        end
        return {1'b0, fpmf};
    endfunction

    function automatic lcr_byte_t read_mux(input lcr_addr_t a);
        case (a)
            `LCR_OFS_ENABLE: read_mux = link_enable_reg;
            `LCR_OFS_MODE: read_mux = link_mode_reg;
            `LCR_OFS_FPMF: read_mux = frames_per_multiframe_reg;
            `LCR_OFS_SYNC: read_mux = software_sync_request_reg;
            `LCR_OFS_CTRL: read_mux = link_control_reg;
            default: read_mux = '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link_enable_reg <= `LCR_RST_ENABLE;
        end else if (is_write(`LCR_OFS_ENABLE)) begin
            link_enable_reg <= link.reg_wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link_mode_reg <= `LCR_RST_MODE;
        end else if (is_write(`LCR_OFS_MODE) && mode_allowed(link.reg_wdata, mode_lock_in)) begin
            link_mode_reg <= link.reg_wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            frames_per_multiframe_reg <= `LCR_RST_FPMF;
        end else if (is_write(`LCR_OFS_FPMF)) begin
            frames_per_multiframe_reg <= link.reg_wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            software_sync_request_reg <= `LCR_RST_SYNC;
        end else if (is_write(`LCR_OFS_SYNC)) begin
            software_sync_request_reg <= link.reg_wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link_control_reg <= `LCR_RST_CTRL;
        end else if (is_write(`LCR_OFS_CTRL)) begin
            link_control_reg <= link.reg_wdata;
        end
    end

    // Reads answer one cycle later; unmapped offsets read zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_reg <= '0;
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rdata_reg <= link.reg_rd ? read_mux(link.reg_addr) : '0;
            reg_rvalid_reg <= link.reg_rd && !link.reg_wr;
        end
    end

    assign link.reg_rdata = reg_rdata_reg;
    assign link.reg_rvalid = reg_rvalid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded state

    assign link_enable = link_enable_reg[`LCR_BIT_EN];
    assign mode_is_66b = is_66b(link_mode_reg);
    assign sync_source = link_control_reg[`LCR_SEL_HI:`LCR_SEL_LO];

    assign k_minus_one = derive_k(link_mode_reg, frames_per_multiframe_reg);

    always_comb begin
        case (sync_source)
            `LCR_SEL_SE: pin_request = !link.single_ended_sync_pin_n;
            `LCR_SEL_TS: pin_request = !link.timestamp_pin_n && timestamp_receiver_enable_in;
            default: pin_request = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link control outputs

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link_reset_out <= 1'b0;
            link_clock_enable_out <= 1'b1;
        end else begin
            link_reset_out <= !link_enable;
            link_clock_enable_out <= link_enable;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            serializer_power_down_out <= `LCR_LANES_UPPER_OFF;
        end else if (!link_enable) begin
            serializer_power_down_out <= `LCR_LANES_ALL;
        end else if (link_control_reg[`LCR_BIT_UPPER]) begin
            serializer_power_down_out <= `LCR_LANES_LOWER_OFF;
        end else begin
            serializer_power_down_out <= `LCR_LANES_UPPER_OFF;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sample_format_out <= 1'b1;
            whitening_enable_out <= 1'b1;
        end else begin
            sample_format_out <= link_control_reg[`LCR_BIT_FMT];
            whitening_enable_out <= mode_is_66b || link_control_reg[`LCR_BIT_SCR];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync_request_out <= 1'b0;
        end else begin
            sync_request_out <= !software_sync_request_reg[`LCR_BIT_SYNC] || pin_request;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            frames_per_multiframe_minus_one_out <= {1'b0, `LCR_RST_FPMF};
        end else begin
            frames_per_multiframe_minus_one_out <= k_minus_one;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multiframe counter

    lcr_mf_counter u_mf_counter (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .hold_in(!link_enable),
        .sysref_in(link.sysref),
        .k_minus_one_in(k_minus_one),
        .count_out(multiframe_count_out),
        .start_out(multiframe_start_out)
    );
endmodule // lcr_device

// >>> hw/lcr_host.sv
// Host end: AHB-Lite command registers driving the converter register port
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_host (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Converter side
    lcr_if.host link
);
    import lcr_pkg::*;

    lcr_host_state_e state_reg;
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    lcr_addr_t addr_reg;
    lcr_byte_t wdata_reg;
    lcr_byte_t rdata_reg;
    logic wr_reg;
    logic rd_reg;
    logic shadow_enable_reg;
    logic refused_reg;
    logic [3:0] pins_reg;
    logic wr_cmd;
    logic wr_status;
    logic wr_pins;
    logic cmd_go;
    logic cmd_bad;
    logic cal_bad;
    lcr_addr_t c_addr;
    lcr_byte_t c_data;
    logic c_wr;

    function automatic logic refuse(input lcr_addr_t a, input lcr_byte_t d, input logic w);
        logic bad;
        bad = 1'b0;
        if (w) begin
            if (a == `LCR_OFS_ENABLE && d[`LCR_BIT_EN] && !pins_reg[`LCR_PIN_CAL]) begin
                bad = 1'b1;
            end
            // mode needs enable and calibration off
            if (a == `LCR_OFS_MODE && (shadow_enable_reg || pins_reg[`LCR_PIN_CAL])) begin
                bad = 1'b1;
            end
            if ((a == `LCR_OFS_FPMF || a == `LCR_OFS_CTRL) && shadow_enable_reg) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= '0;
        end else begin
            dp_valid_reg <= hsel_in && htrans_in[`LCR_HTRANS_ACT] && hready_in
                && (hsize_in == `LCR_HSIZE_WORD);
            dp_write_reg <= hwrite_in;
            dp_addr_reg <= haddr_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hrdata_out <= '0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            hrdata_out <= '0;
            if (hsel_in && htrans_in[`LCR_HTRANS_ACT] && hready_in && !hwrite_in) begin
                case (haddr_in[7:0])
                    `LCR_AHB_CMD: hrdata_out <= {7'h00, wr_reg, 4'h0, wdata_reg, addr_reg};
                    `LCR_AHB_STATUS: hrdata_out <= {16'h0000, rdata_reg, 6'h00,
                        refused_reg, state_reg != LCR_HS_IDLE};
                    `LCR_AHB_PINS: hrdata_out <= {28'h0000000, pins_reg};
                    default: hrdata_out <= '0;
                endcase
            end
        end
    end

    assign wr_cmd = dp_valid_reg && dp_write_reg && (dp_addr_reg == `LCR_AHB_CMD);
    assign wr_status = dp_valid_reg && dp_write_reg && (dp_addr_reg == `LCR_AHB_STATUS);
    assign wr_pins = dp_valid_reg && dp_write_reg && (dp_addr_reg == `LCR_AHB_PINS);
    assign c_addr = hwdata_in[`LCR_CMD_A_HI:`LCR_CMD_A_LO];
    assign c_data = hwdata_in[`LCR_CMD_D_HI:`LCR_CMD_D_LO];
    assign c_wr = hwdata_in[`LCR_CMD_WR];
    assign cmd_bad = (state_reg != LCR_HS_IDLE) || refuse(c_addr, c_data, c_wr);
    assign cmd_go = wr_cmd && !cmd_bad;
    assign cal_bad = wr_pins && shadow_enable_reg && pins_reg[`LCR_PIN_CAL]
        && !hwdata_in[`LCR_PIN_CAL];

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= LCR_HS_IDLE;
        end else begin
            case (state_reg)
                LCR_HS_IDLE: begin
                    if (cmd_go) begin
                        state_reg <= c_wr ? LCR_HS_WRITE : LCR_HS_READ;
                    end
                end
                LCR_HS_WRITE: state_reg <= LCR_HS_IDLE;
                LCR_HS_READ: begin
                    if (link.reg_rvalid) begin
                        state_reg <= LCR_HS_IDLE;
                    end
                end
                default: state_reg <= LCR_HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            addr_reg <= '0;
            wdata_reg <= '0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            wr_reg <= cmd_go && c_wr;
            rd_reg <= cmd_go && !c_wr;
            if (cmd_go) begin
                addr_reg <= c_addr;
                wdata_reg <= c_data;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_reg <= '0;
        end else if (state_reg == LCR_HS_READ && link.reg_rvalid) begin
            rdata_reg <= link.reg_rdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shadow_enable_reg <= 1'(`LCR_RST_ENABLE);
        end else if (cmd_go && c_wr && c_addr == `LCR_OFS_ENABLE) begin
            shadow_enable_reg <= c_data[`LCR_BIT_EN];
        end
    end

    // Refusal flag: set wins over write-one-to-clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            refused_reg <= 1'b0;
        end else if ((wr_cmd && cmd_bad) || cal_bad) begin
            refused_reg <= 1'b1;
        end else if (wr_status && hwdata_in[`LCR_ST_REFUSED]) begin
            refused_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pins_reg <= `LCR_PINS_RST;
        end else if (wr_pins) begin
            pins_reg <= hwdata_in[3:0];
            if (cal_bad) begin
                pins_reg[`LCR_PIN_CAL] <= 1'b1;
            end
        end
    end

    assign link.reg_addr = addr_reg;
    assign link.reg_wdata = wdata_reg;
    assign link.reg_wr = wr_reg;
    assign link.reg_rd = rd_reg;
    assign link.single_ended_sync_pin_n = pins_reg[`LCR_PIN_SE];
    assign link.timestamp_pin_n = pins_reg[`LCR_PIN_TS];
    assign link.sysref = pins_reg[`LCR_PIN_SYSREF];
    assign link.cal_enable = pins_reg[`LCR_PIN_CAL];
endmodule // lcr_host

// >>> testbench/lcr_link_props.sv
// Concurrent checks on the converter register port and link outputs
`timescale 1ns/1ps
module lcr_link_props (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire lcr_pkg::lcr_addr_t reg_addr,
    input wire lcr_pkg::lcr_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire lcr_pkg::lcr_byte_t reg_rdata,
    input wire logic reg_rvalid,
    // Link outputs
    input wire logic link_reset_out,
    input wire logic link_clock_enable_out,
    input wire lcr_pkg::lcr_byte_t serializer_power_down_out,
    input wire logic sync_request_out,
    input wire lcr_pkg::lcr_kcount_t multiframe_count_out
);
    import lcr_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic en_wr = reg_wr && reg_addr == 12'h200;
    ////////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (
        reg_rd && !reg_wr |=> reg_rvalid) else $error("read not answered");
    answer_cause_a: assert property (
        reg_rvalid |-> $past(reg_rd) && !$past(reg_wr)) else $error("answer without read");
    idle_data_a: assert property (
        !reg_rvalid |-> reg_rdata == 8'h00) else $error("read data not idle");
    disable_link_a: assert property (
        en_wr && !reg_wdata[0] |-> ##2 link_reset_out && !link_clock_enable_out
        && serializer_power_down_out == 8'hff) else $error("link not shut down");
    enable_link_a: assert property (
        en_wr && reg_wdata[0] |-> ##2 !link_reset_out) else $error("link not enabled");
    counter_held_a: assert property (
        link_reset_out [*2] |-> multiframe_count_out == 9'h000) else $error("counter ran");
    sw_sync_a: assert property (
        reg_wr && reg_addr == 12'h203 && !reg_wdata[0] |-> ##2 sync_request_out)
        else $error("software sync ignored");
    reset_state_a: assert property (
        $fell(rst_in) |-> !link_reset_out && link_clock_enable_out
        && serializer_power_down_out == 8'hf0) else $error("bad reset state");
endmodule // lcr_link_props

// >>> testbench/jesd_link_control_regs_bench.sv
// Bench joining host and converter ends over the register port
`timescale 1ns/1ps
module jesd_link_control_regs_bench;
    import lcr_pkg::*;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, ts_en = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hready, hresp, lrst, cken, fmt, whit, sreq;
    lcr_byte_t lock = 8'h17, pd, m, nm, k, c;
    lcr_kcount_t kout, cnt;
    integer errors = 0, tests_run = 0, seed = 6, i;
    lcr_if link ();
    lcr_host u_lcr_host (.clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .link(link));
    lcr_device u_lcr_device (.clk_in(clk), .rst_in(rst), .mode_lock_in(lock),
        .timestamp_receiver_enable_in(ts_en), .link(link), .link_reset_out(lrst),
        .link_clock_enable_out(cken), .serializer_power_down_out(pd),
        .sample_format_out(fmt), .whitening_enable_out(whit), .sync_request_out(sreq),
        .frames_per_multiframe_minus_one_out(kout), .multiframe_count_out(cnt),
        .multiframe_start_out());
    lcr_link_props u_lcr_link_props (.clk_in(clk), .rst_in(rst),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
        .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid),
        .link_reset_out(lrst), .link_clock_enable_out(cken),
        .serializer_power_down_out(pd), .sync_request_out(sreq),
        .multiframe_count_out(cnt));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clk = ~clk;
    end
    task conclude;
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single word transfer, zero or more wait states
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (!hready) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (!hready) @(posedge clk);
        r = hrdata;
    endtask
    // Device access through the command register, polled until idle
    task dev(input logic w, input logic [11:0] a, input logic [7:0] d);
        ahb(1'b1, 8'h00, {7'h0, w, 4'h0, d, a});
        do ahb(1'b0, 8'h04, 32'h0); while (r[0] !== 1'b0);
    endtask
    task rdv(input logic [11:0] a, input logic [7:0] e);
        dev(1'b0, a, 8'h00);
        chk(32'(r[15:8]), 32'(e));
    endtask
    task pins(input logic [3:0] p);
        ahb(1'b1, 8'h08, {28'h0, p});
        repeat (4) @(posedge clk);
    endtask
    // Sticky refusal flag against expectation, then cleared
    task refused(input logic e);
        ahb(1'b0, 8'h04, 32'h0);
        chk(32'(r[1]), 32'(e));
        ahb(1'b1, 8'h04, 32'h2);
    endtask
    // K-1: field value, or 256*E/F - 1 with E = 1 + mode[2], F = 2**mode[1:0]
    function automatic lcr_kcount_t kexp(input lcr_byte_t md, input lcr_byte_t km);
        if (md < 8'h10) return {1'b0, km};
        return 9'(256 * (1 + md[2]) / (1 << md[1:0]) - 1);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdv(12'h200, 8'h01);
        rdv(12'h201, 8'h02);
        rdv(12'h202, 8'h1f);
        rdv(12'h203, 8'h01);
        rdv(12'h204, 8'h03);
        rdv(12'h205, 8'h00);
        dev(1'b1, 12'h201, 8'h05);
        refused(1'b1);
        rdv(12'h201, 8'h02);
        m = 8'h02;
        for (i = 0; i < 6; i++) begin
            dev(1'b1, 12'h200, 8'h00);
            pins(4'hb);
            pins(4'h3);
            chk(32'({lrst, cken, pd}), 32'h2ff);
            chk(32'(cnt), 32'h0);
            nm = (i == 0) ? lock + 8'h01 : (i == 1) ? lock : 8'($random(seed)) & 8'h1f;
            dev(1'b1, 12'h201, nm);
            if (nm <= lock) m = nm;
            rdv(12'h201, m);
            k = 8'($random(seed));
            dev(1'b1, 12'h202, k);
            rdv(12'h202, k);
            c = 8'($random(seed));
            c[3:2] = 2'(i % 3);
            dev(1'b1, 12'h204, c);
            rdv(12'h204, c);
            pins(4'h7);
            dev(1'b1, 12'h200, 8'h01);
            repeat (2) @(posedge clk);
            chk(32'({lrst, cken, pd}), {22'h0, 2'b01, c[4] ? 8'h0f : 8'hf0});
            chk(32'({fmt, whit}), 32'({c[1], c[0] | (m >= 8'h10)}));
            chk(32'(kout), 32'(kexp(m, k)));
            chk(32'(sreq), 32'h0);
            pins(4'h6);
            chk(32'(sreq), 32'(c[3:2] == 2'h0));
            pins(4'h5);
            chk(32'(sreq), 32'(c[3:2] == 2'h1));
            pins(4'h4);
            chk(32'(sreq), 32'(c[3:2] != 2'h2));
            pins(4'h7);
            dev(1'b1, 12'h203, 8'h00);
            repeat (2) @(posedge clk);
            chk(32'(sreq), 32'h1);
            dev(1'b1, 12'h203, 8'h01);
            repeat (2) @(posedge clk);
            chk(32'(sreq), 32'h0);
        end
        // SYSREF edge while enabled realigns the counter to zero
        pins(4'hf);
        @(negedge clk);
        chk(32'(cnt), 32'(3 % (kexp(m, k) + 1)));
        dev(1'b1, 12'h202, ~k);
        refused(1'b1);
        rdv(12'h202, k);
        pins(4'h3);
        refused(1'b1);
        ahb(1'b0, 8'h08, 32'h0);
        chk(32'(r[3:0]), 32'h7);
        dev(1'b1, 12'h200, 8'h00);
        pins(4'h3);
        refused(1'b0);
        dev(1'b1, 12'h200, 8'h01);
        refused(1'b1);
        rdv(12'h200, 8'h00);
        conclude;
    end
    initial begin
        #200000;
        errors++;
        conclude;
    end
endmodule // jesd_link_control_regs_bench
